// >>> carrier_pulse_modulator_cfg.svh
// offsets, field positions, reset values and divisors of the carrier pulse modulator
// Contract
// [RULE1] pad held low for on-time field plus one clocks each period
// [RULE2] duty 001/010/011 give off-time one, two, three times on-time
// [RULE3] duty 100/101 give on-time two or three times base, off equals base
// [RULE4] period from 2 to 128 clocks, shortest at field 0, longest at 31
// [RULE5] duty zero: no modulation, pad follows its latch bit
// [RULE6] duty 111 gives a carrier at chip clock frequency, one-clock period
// [RULE7] high-frequency pad output is gated by the chip clock itself
// [RULE8] software sets latch high before leaving high-frequency mode
// [RULE9] latch 1 gives pad 1; latch 0 gives 0 or modulated by duty
// [RULE10] modulated pad is always an output
// [RULE11] one count enable to the timer per completed modulation period; the code gives none for a period ending with duty 000 or 110 selected
// [RULE12] period count source runs while latch high and modulation stopped
// [RULE13] software preloads timer with 255 minus N for an N-pulse burst
// [RULE14] timer overflow can change the pad latch automatically
// [RULE15] software programs control first, then starts by clearing the latch
// [RULE16] after latch goes low the pad goes low at next period start
// [RULE17] software stops by setting latch or overflow set action
// [RULE18] control write during modulation takes effect at next period start; the code applies duty 000 or 110 to the pad at once
// [RULE19] overflow action 00 none, 01 toggle, 10 clear, 11 set, also forced
// [RULE20] timer clock select second encoding picks the modulator period
// [RULE21] duty 110 reserved, treated like the unmodulated setting
// [RULE22] on then off phase from a clock counter, control sampled at boundary
`ifndef CARRIER_PULSE_MODULATOR_CFG_SVH
`define CARRIER_PULSE_MODULATOR_CFG_SVH

// register indices; byte address is four times the index
`define PORT_A_IDX        6'h00
`define TIMER0_CTRL_IDX   6'h01
`define MOD_CTRL_IDX      6'h02
`define TIMER0_COUNT_IDX  6'h03
`define STATUS_IDX        6'h04

// reset values
`define PORT_A_RESET      8'h00
`define TIMER0_CTRL_RESET 8'h00
`define MOD_CTRL_RESET    8'h00
`define TIMER0_COUNT_RESET 8'h00

// field positions
`define LED_LATCH_BIT     2
`define ON_COUNT_HI       7
`define ON_COUNT_LO       3
`define DUTY_HI           2
`define DUTY_LO           0
`define FORCE_OVF_BIT     7
`define OOM_HI            4
`define OOM_LO            3
`define CS_HI             2
`define CS_LO             0

// timer prescale divisor exponents: 64, 256, 1024
`define DIV_BITS          10
`define DIV64_LOG         6
`define DIV256_LOG        8
`define DIV1024_LOG       10

`endif

// >>> carrier_pulse_modulator_pkg.sv
// types shared by the carrier pulse modulator files
package carrier_pulse_modulator_pkg;

	typedef enum logic [2:0] {
		DUTY_OFF       = 3'b000,
		DUTY_HALF      = 3'b001,
		DUTY_THIRD     = 3'b010,
		DUTY_QUARTER   = 3'b011,
		DUTY_TWO_THIRD = 3'b100,
		DUTY_THREE_QTR = 3'b101,
		DUTY_RESERVED  = 3'b110,
		DUTY_HIGH_FREQ = 3'b111
	} duty_cfg_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ON   = 2'b01,
		PH_OFF  = 2'b10
	} phase_t;

	typedef enum logic [2:0] {
		CS_STOP    = 3'b000,
		CS_CK      = 3'b001,
		CS_MODPER  = 3'b010,
		CS_DIV64   = 3'b011,
		CS_DIV256  = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_EXT_FALL = 3'b110,
		CS_EXT_RISE = 3'b111
	} clk_sel_t;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR  = 2'b10,
		ACT_SET    = 2'b11
	} pin_action_t;

endpackage

// >>> prescale_divider.sv
// free-running chip clock divider giving /64, /256 and /1024 tick pulses
`timescale 1ns/10ps
`default_nettype none
`include "carrier_pulse_modulator_cfg.svh"

module prescale_divider (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic [2:0]      tick_o
);
	import carrier_pulse_modulator_pkg::*;

	typedef struct packed {
		logic [`DIV_BITS-1:0] cnt;
		logic [2:0]           tick;
	} div_state_t;

	localparam int unsigned LOGS [3] = '{`DIV64_LOG, `DIV256_LOG, `DIV1024_LOG};

	div_state_t st_ff;
	div_state_t nxt_st;

	// taps fire when the low bits of the counter are all ones
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.cnt = st_ff.cnt + `DIV_BITS'(1);
		for (int i = 0; i < 3; i++) begin
			nxt_st.tick[i] = &(st_ff.cnt | ~((`DIV_BITS'(1) << LOGS[i]) - `DIV_BITS'(1)));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick_o = st_ff.tick;
endmodule
`default_nettype wire

// >>> modulation_sequencer.sv
// on/off phase sequencer of the carrier, one count enable per period except one ending with duty 000 or 110 selected
`timescale 1ns/10ps
`default_nettype none
`include "carrier_pulse_modulator_cfg.svh"

module modulation_sequencer (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] mod_ctrl_i,
	input  wire logic       led_pin_latch_i,
	output logic            drive_low_o,
	output logic            high_freq_o,
	output logic            count_en_o
);
	import carrier_pulse_modulator_pkg::*;

	typedef struct packed {
		phase_t     phase;
		logic [6:0] cnt;
		logic [6:0] off_len;
		logic       en;
		logic       hf;
		logic       tick;
	} seq_state_t;

	seq_state_t st_ff;
	seq_state_t nxt_st;
	logic       boundary;
	logic [6:0] base;
	logic [6:0] on_len;
	logic [6:0] off_len;
	duty_cfg_t  duty;

	// phase lengths from the base count
	always_comb begin
		duty = duty_cfg_t'(mod_ctrl_i[`DUTY_HI:`DUTY_LO]);
		base = {2'b00, mod_ctrl_i[`ON_COUNT_HI:`ON_COUNT_LO]} + 7'h01;  // [RULE1] [RULE4]
		case (duty)
			DUTY_TWO_THIRD: on_len = 7'(base * 2);  // [RULE3]
			DUTY_THREE_QTR: on_len = 7'(base * 3);  // [RULE3]
			default:        on_len = base;
		endcase
		case (duty)
			DUTY_THIRD:   off_len = 7'(base * 2);  // [RULE2]
			DUTY_QUARTER: off_len = 7'(base * 3);  // [RULE2]
			default:      off_len = base;
		endcase
	end

	// control sampled only at a period boundary
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.tick = 1'b0;
		nxt_st.en   = st_ff.en & ~led_pin_latch_i;
		nxt_st.hf   = st_ff.hf & ~led_pin_latch_i;
		boundary    = (st_ff.phase == PH_IDLE) ||
			(st_ff.phase == PH_OFF && st_ff.cnt == 7'h01);  // [RULE22]
		case (st_ff.phase)
			PH_ON: begin
				nxt_st.cnt = st_ff.cnt - 7'h01;
				if (st_ff.cnt == 7'h01) begin
					nxt_st.phase = PH_OFF;
					nxt_st.cnt   = st_ff.off_len;
				end
			end
			PH_OFF: begin
				nxt_st.cnt = st_ff.cnt - 7'h01;
				if (st_ff.cnt == 7'h01) begin
					nxt_st.tick = 1'b1;  // [RULE11] [RULE12]
				end
			end
			default: begin
				nxt_st.cnt = st_ff.cnt;
			end
		endcase
		if (boundary) begin  // [RULE18]
			nxt_st.hf = 1'b0;
			if (duty >= DUTY_HALF && duty <= DUTY_THREE_QTR) begin
				nxt_st.phase   = PH_ON;
				nxt_st.cnt     = on_len;
				nxt_st.off_len = off_len;
				nxt_st.en      = ~led_pin_latch_i;  // [RULE16]
			end else begin
				nxt_st.phase = PH_IDLE;  // [RULE5] [RULE21]
				nxt_st.en    = 1'b0;
				nxt_st.hf    = (duty == DUTY_HIGH_FREQ) & ~led_pin_latch_i;  // [RULE6]
				nxt_st.tick  = (duty == DUTY_HIGH_FREQ);  // [RULE6] [RULE11]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign drive_low_o = st_ff.en & (st_ff.phase == PH_ON);  // [RULE1]
	assign high_freq_o = st_ff.hf;
	assign count_en_o  = st_ff.tick;
endmodule
`default_nettype wire

// >>> carrier_pulse_modulator.sv
// carrier pulse modulator top: wishbone registers, timer0 and led pad
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "carrier_pulse_modulator_cfg.svh"

module carrier_pulse_modulator (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	// classic wishbone slave
	input  wire logic                                 cyc_i,
	input  wire logic                                 stb_i,
	input  wire logic                                 we_i,
	input  wire logic [7:0]                           adr_i,
	input  wire logic [3:0]                           sel_i,
	input  wire logic [31:0]                          dat_i,
	output logic      [31:0]                          dat_o,
	output logic                                      ack_o,
	// external timer count pin, synchronous to clk_i
	input  wire logic                                 t0_pin_i,
	// timer state seen outside
	output var carrier_pulse_modulator_pkg::clk_sel_t timer_clk_sel_o,
	output logic                                      timer_overflow_o,
	// high-current led pad, active low
	output logic                                      led_drive_pin_o,
	output logic                                      led_drive_pin_oe_o
);
	import carrier_pulse_modulator_pkg::*;

	// complete register state of the top
	typedef struct packed {
		logic        ack;
		logic [7:0]  rdata;
		logic [7:0]  port_a_latch;
		pin_action_t oom;
		clk_sel_t    cs;
		logic [7:0]  mod_ctrl;
		logic [7:0]  count;
		logic        t0_prev;
		logic        ovf;
		logic        pin;
		logic        hf;
		logic        oe;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;

	// wires from the two submodules
	logic [2:0] div_tick;
	logic       seq_drive_low;
	logic       seq_high_freq;
	logic       seq_count_en;

	// decoded bus request
	logic       req;
	logic       wr;
	logic [5:0] idx;

	// timer and pad working terms
	logic       timer_tick;
	logic       sw_count_wr;
	logic       force_ovf;
	logic       overflow;
	logic       latch_now;
	logic       pad_level;
	duty_cfg_t  duty_now;

	// true when a word index names a mapped register
	function automatic logic reg_mapped(input logic [5:0] i);
		case (i)
			`PORT_A_IDX,
			`TIMER0_CTRL_IDX,
			`MOD_CTRL_IDX,
			`TIMER0_COUNT_IDX,
			`STATUS_IDX: reg_mapped = 1'b1;
			default:     reg_mapped = 1'b0;
		endcase
	endfunction

	// true when a write strobe hits a given register with lane 0 enabled
	function automatic logic reg_write_hit(
		input logic       w,
		input logic [5:0] i,
		input logic [5:0] target,
		input logic [3:0] sel
	);
		reg_write_hit = w && (i == target) && sel[0] && reg_mapped(i);
	endfunction

	// new latch bit after an overflow action
	function automatic logic apply_action(input pin_action_t a, input logic cur);
		case (a)
			ACT_TOGGLE: apply_action = ~cur;
			ACT_CLEAR:  apply_action = 1'b0;
			ACT_SET:    apply_action = 1'b1;
			default:    apply_action = cur;
		endcase
	endfunction

	// timer clock source picked by the clock select
	function automatic logic pick_source(
		input clk_sel_t   sel,
		input logic       mod_tick,
		input logic [2:0] div,
		input logic       ext_now,
		input logic       ext_prev
	);
		case (sel)
			CS_STOP:     pick_source = 1'b0;
			CS_CK:       pick_source = 1'b1;
			CS_MODPER:   pick_source = mod_tick;
			CS_DIV64:    pick_source = div[0];
			CS_DIV256:   pick_source = div[1];
			CS_DIV1024:  pick_source = div[2];
			CS_EXT_FALL: pick_source = ext_prev & ~ext_now;
			CS_EXT_RISE: pick_source = ~ext_prev & ext_now;
			default:     pick_source = 1'b0;
		endcase
	endfunction

	// register contents as software reads them
	function automatic logic [7:0] read_word(input logic [5:0] i, input top_state_t s);
		case (i)
			`PORT_A_IDX:       read_word = s.port_a_latch;
			`TIMER0_CTRL_IDX:  read_word = {3'b000, s.oom, s.cs};
			`MOD_CTRL_IDX:     read_word = s.mod_ctrl;
			`TIMER0_COUNT_IDX: read_word = s.count;
			`STATUS_IDX:       read_word = {5'b00000, s.hf, s.ovf, s.pin};
			default:           read_word = 8'h00;
		endcase
	endfunction

	// chip clock divider for the timer prescale taps
	prescale_divider u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (div_tick)
	);

	// carrier phase sequencer, always running, control word taken at each period boundary
	modulation_sequencer u_seq (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.mod_ctrl_i      (st_ff.mod_ctrl),
		.led_pin_latch_i (st_ff.port_a_latch[`LED_LATCH_BIT]),
		.drive_low_o     (seq_drive_low),
		.high_freq_o     (seq_high_freq),
		.count_en_o      (seq_count_en)
	);

	// bus decode: one request per cycle until ack is given
	always_comb begin
		req = cyc_i && stb_i && !st_ff.ack;
		wr  = req && we_i;
		idx = adr_i[7:2];
	end

	// timer source, software writes and overflow detection
	always_comb begin
		timer_tick  = pick_source(st_ff.cs, seq_count_en, div_tick,
			t0_pin_i, st_ff.t0_prev);  // [RULE20] [RULE11]
		sw_count_wr = reg_write_hit(wr, idx, `TIMER0_COUNT_IDX, sel_i);
		force_ovf   = reg_write_hit(wr, idx, `TIMER0_CTRL_IDX, sel_i) &&
			dat_i[`FORCE_OVF_BIT];
		overflow    = timer_tick && (st_ff.count == 8'hff) && !sw_count_wr;
	end

	// next state of the whole top
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.t0_prev = t0_pin_i;
		nxt_st.oe      = 1'b1;  // [RULE10]

		// wishbone answer, one cycle after the request
		nxt_st.ack   = req;
		nxt_st.rdata = req ? read_word(idx, st_ff) : 8'h00;

		// software writes, lane 0 only
		if (reg_write_hit(wr, idx, `PORT_A_IDX, sel_i)) begin
			nxt_st.port_a_latch = dat_i[7:0];
		end
		if (reg_write_hit(wr, idx, `TIMER0_CTRL_IDX, sel_i)) begin
			nxt_st.oom = pin_action_t'(dat_i[`OOM_HI:`OOM_LO]);
			nxt_st.cs  = clk_sel_t'(dat_i[`CS_HI:`CS_LO]);
		end
		if (reg_write_hit(wr, idx, `MOD_CTRL_IDX, sel_i)) begin
			nxt_st.mod_ctrl = dat_i[7:0];  // [RULE18]
		end

		// timer count: a write wins, counting resumes next tick
		if (sw_count_wr) begin
			nxt_st.count = dat_i[7:0];
		end else if (timer_tick) begin
			nxt_st.count = st_ff.count + 8'h01;
		end

		// overflow or forced overflow acts on the led latch bit
		nxt_st.ovf = overflow || force_ovf;
		if (overflow || force_ovf) begin
			nxt_st.port_a_latch[`LED_LATCH_BIT] = apply_action(st_ff.oom,
				nxt_st.port_a_latch[`LED_LATCH_BIT]);  // [RULE14] [RULE19]
		end

		// pad and high-frequency flags follow a set latch bit without waiting
		nxt_st.pin = pad_level;
		nxt_st.hf  = seq_high_freq && !latch_now;
	end

	// pad level from latch and duty setting
	always_comb begin
		latch_now = st_ff.port_a_latch[`LED_LATCH_BIT];
		duty_now  = duty_cfg_t'(st_ff.mod_ctrl[`DUTY_HI:`DUTY_LO]);
		if (latch_now) begin
			pad_level = 1'b1;  // [RULE9]
		end else if (duty_now == DUTY_OFF || duty_now == DUTY_RESERVED) begin
			pad_level = 1'b0;  // [RULE5] [RULE21]
		end else begin
			pad_level = ~seq_drive_low;  // [RULE9] [RULE16]
		end
	end

	// single register stage for all top state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff.ack          <= 1'b0;
			st_ff.rdata        <= 8'h00;
			st_ff.port_a_latch <= `PORT_A_RESET;
			st_ff.oom          <= ACT_NONE;
			st_ff.cs           <= CS_STOP;
			st_ff.mod_ctrl     <= `MOD_CTRL_RESET;
			st_ff.count        <= `TIMER0_COUNT_RESET;
			st_ff.t0_prev      <= 1'b0;
			st_ff.ovf          <= 1'b0;
			st_ff.pin          <= 1'b0;
			st_ff.hf           <= 1'b0;
			st_ff.oe           <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// bus outputs straight from flops
	assign ack_o = st_ff.ack;
	assign dat_o = {24'h000000, st_ff.rdata};

	// timer outputs
	assign timer_clk_sel_o  = st_ff.cs;
	assign timer_overflow_o = st_ff.ovf;

	// high-frequency carrier: pad gated by the chip clock, low while clock low
	assign led_drive_pin_o    = st_ff.hf ? clk_i : st_ff.pin;  // [RULE7] [RULE6]
	assign led_drive_pin_oe_o = st_ff.oe;  // [RULE10]
endmodule
`default_nettype wire

// >>> carrier_pulse_modulator_properties.sv
// concurrent checks on the carrier pulse modulator ports
`timescale 1ns/10ps
`default_nettype none
module carrier_pulse_modulator_checker (
	input wire logic                             clk_i,
	input wire logic                             rst_i,
	input wire logic                             cyc_i,
	input wire logic                             stb_i,
	input wire logic                             we_i,
	input wire logic [7:0]                       adr_i,
	input wire logic [3:0]                       sel_i,
	input wire logic [31:0]                      dat_i,
	input wire logic [31:0]                      dat_o,
	input wire logic                             ack_o,
	input wire carrier_pulse_modulator_pkg::clk_sel_t timer_clk_sel_o,
	input wire logic                             timer_overflow_o,
	input wire logic                             led_drive_pin_o,
	input wire logic                             led_drive_pin_oe_o
);
	import carrier_pulse_modulator_pkg::*;
	logic take;
	// request taken at this edge
	assign take = cyc_i && stb_i && !ack_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	pad_output_a: assert property (led_drive_pin_oe_o) else $error("pad not output");
	ack_answer_a: assert property (take |=> ack_o) else $error("no ack");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not idle");
	dat_lane_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper lanes set");
	ovf_pulse_a: assert property (timer_overflow_o |=> !timer_overflow_o)
		else $error("overflow pulse long");
	latch_high_a: assert property (
		take && we_i && sel_i[0] && adr_i[7:2] == 6'h00 && dat_i[2] |=> ##1 led_drive_pin_o)
		else $error("pad not high");
	clk_sel_a: assert property (
		take && we_i && sel_i[0] && adr_i[7:2] == 6'h01 |=> timer_clk_sel_o == $past(dat_i[2:0]))
		else $error("clock select");
	cover property (timer_overflow_o);
	cover property (take && we_i && adr_i[7:2] == 6'h02);
	cover property ($fell(led_drive_pin_o));
endmodule
`default_nettype wire

// >>> led_model.sv
// led on the pad: measures the last low and high run lengths
`timescale 1ns/10ps
`default_nettype none
module led_model (
	input wire logic  clk_i,
	input wire logic  pad_i,
	input wire logic  oe_i,
	output logic [7:0] low_len_o,
	output logic [7:0] high_len_o
);
	logic       prev;
	logic [7:0] run;
	initial begin
		prev = 1'b1;
		run = 8'h00;
		low_len_o = 8'h00;
		high_len_o = 8'h00;
	end
	// lit only while driven low
	always @(negedge clk_i) begin
		if ((pad_i & oe_i) === prev) begin
			run <= run + 8'h01;
		end else begin
			if (prev) high_len_o <= run;
			else low_len_o <= run;
			run <= 8'h01;
		end
		prev <= pad_i & oe_i;
	end
endmodule
`default_nettype wire

// >>> carrier_pulse_modulator_tb.sv
// self-checking bench of the carrier pulse modulator
`timescale 1ns/10ps
`default_nettype none
module carrier_pulse_modulator_tb;
	import carrier_pulse_modulator_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack, ovf, pad, pad_oe, t0;
	logic [7:0]  adr, q, low_len, high_len;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r;
	clk_sel_t    csel;
	int          mismatches, samples_checked, cycles;
	carrier_pulse_modulator dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
		.t0_pin_i(t0), .timer_clk_sel_o(csel), .timer_overflow_o(ovf),
		.led_drive_pin_o(pad), .led_drive_pin_oe_o(pad_oe));
	led_model led_u (.clk_i(clk_i), .pad_i(pad), .oe_i(pad_oe), .low_len_o(low_len),
		.high_len_o(high_len));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	// one classic cycle, entered and left at a rising edge
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; dat_w <= {24'h0, d};
		// hold until ack is seen at a rising edge; only the bench timeout ends a hang
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_r[7:0];
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_reset;
		chk("pad", 32'h0, pad);
		wb(0, 8'h08, 8'h00);
		chk("mod_ctrl", 32'h0, q);
		wb(0, 8'h40, 8'h00);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
	endtask
	task t_duty;
		logic [7:0] cfg [7], lo [7], hi [7];
		cfg = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h03, 8'hf9};
		lo = '{8'd3, 8'd3, 8'd3, 8'd6, 8'd9, 8'd1, 8'd32};
		hi = '{8'd3, 8'd6, 8'd9, 8'd3, 8'd3, 8'd3, 8'd32};
		wb(1, 8'h00, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wb(1, 8'h08, cfg[i]);
			wb(0, 8'h08, 8'h00);
			chk("mod_ctrl", cfg[i], q);
			repeat (150) @(posedge clk_i);
			chk("on_len", lo[i], low_len);
			chk("off_len", hi[i], high_len);
		end
		$display("test duty done");
	endtask
	task t_hf;
		wb(1, 8'h08, 8'h07);
		repeat (70) @(posedge clk_i); // new mode only after the running 64-clock period
		for (int i = 0; i < 3; i++) begin
			@(negedge clk_i); #1;
			chk("hf_low", 32'h0, pad);
			@(posedge clk_i); #1;
			chk("hf_high", 32'h1, pad);
		end
		@(posedge clk_i);
		wb(1, 8'h00, 8'h04); // stop before leaving the fast mode
		wb(1, 8'h08, 8'h00);
		$display("test hf done");
	endtask
	task t_follow;
		logic [7:0] d [2];
		d = '{8'h00, 8'h06};
		for (int i = 0; i < 2; i++) begin
			wb(1, 8'h08, d[i]);
			wb(1, 8'h00, 8'h04);
			chk("pad_hi", 32'h1, pad);
			wb(1, 8'h00, 8'h00);
			chk("pad_lo", 32'h0, pad);
		end
		$display("test follow done");
	endtask
	task t_source;
		wb(1, 8'h00, 8'h04); // stop by latch
		wb(1, 8'h08, 8'h01);
		wb(1, 8'h04, 8'h02);
		wb(1, 8'h0c, 8'h00);
		repeat (40) @(posedge clk_i);
		wb(0, 8'h0c, 8'h00);
		chk("count_in_range", 32'h1, q >= 8'd19 && q <= 8'd23);
		chk("pad_stopped", 32'h1, pad);
		wb(1, 8'h08, 8'h00);
		wb(1, 8'h0c, 8'h00);
		repeat (40) @(posedge clk_i);
		wb(0, 8'h0c, 8'h00);
		chk("count_idle", 32'h0, q);
		$display("test source done");
	endtask
	task t_clksel;
		wb(1, 8'h04, 8'h00);
		wb(1, 8'h0c, 8'h00);
		wb(1, 8'h04, 8'h01);
		wb(0, 8'h0c, 8'h00);
		chk("count_ck", 32'h2, q);
		wb(1, 8'h04, 8'h00);
		wb(1, 8'h0c, 8'h00);
		wb(1, 8'h04, 8'h03);
		repeat (200) @(posedge clk_i);
		wb(0, 8'h0c, 8'h00);
		chk("count_div64", 32'h1, q >= 8'd3 && q <= 8'd4);
		// falling then rising edges of the timer pin
		for (int i = 0; i < 2; i++) begin
			wb(1, 8'h04, 8'h00);
			wb(1, 8'h0c, 8'h00);
			wb(1, 8'h04, 8'h06 | 8'(i));
			repeat (3) begin
				t0 <= 1'b1;
				@(posedge clk_i);
				t0 <= 1'b0;
				@(posedge clk_i);
			end
			wb(0, 8'h0c, 8'h00);
			chk("count_pin_edges", 32'h3, q);
		end
		$display("test clksel done");
	endtask
	task t_force;
		logic [7:0] e [4];
		e = '{8'h04, 8'h00, 8'h00, 8'h04};
		wb(1, 8'h00, 8'h04);
		for (int i = 0; i < 4; i++) begin
			wb(1, 8'h04, 8'(i << 3)); // action armed before the forced overflow
			wb(1, 8'h04, 8'h80 | 8'(i << 3));
			wb(0, 8'h00, 8'h00);
			chk("latch_forced", e[i], q);
		end
		$display("test force done");
	endtask
	task t_burst;
		int n;
		n = 0;
		wb(1, 8'h08, 8'h01);
		wb(1, 8'h00, 8'h04);
		wb(1, 8'h0c, 8'hfc); // overflow on the fourth period tick
		wb(1, 8'h04, 8'h12); // clear to start
		while (ovf !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
		@(posedge clk_i);
		chk("overflow_seen", 32'h1, n < 100);
		wb(0, 8'h00, 8'h00);
		chk("latch_cleared", 32'h0, q);
		repeat (8) @(posedge clk_i);
		chk("pulse_on", 32'h1, low_len);
		$display("test burst done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles >= 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		rst_i <= 1'b1; cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; adr <= 8'h00; sel <= 4'h0;
		dat_w <= 32'h0; t0 <= 1'b0; mismatches = 0; samples_checked = 0; cycles = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_duty();
		t_hf();
		t_follow();
		t_source();
		t_clksel();
		t_force();
		t_burst();
		give_verdict();
	end
endmodule
bind carrier_pulse_modulator carrier_pulse_modulator_checker chk_u (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .timer_clk_sel_o(timer_clk_sel_o),
	.timer_overflow_o(timer_overflow_o), .led_drive_pin_o(led_drive_pin_o),
	.led_drive_pin_oe_o(led_drive_pin_oe_o));
`default_nettype wire
